// File: phy_regs_consts.svh
// offsets, field positions, reset values and counts of the phy register bank
`ifndef PHY_REGS_CONSTS_SVH
`define PHY_REGS_CONSTS_SVH
// register indices; byte address is four times the index
`define CTRL_IDX 10'h000
`define STAT_IDX 10'h001
`define EXT_IDX 10'h00f
// control register field positions
`define SPD_LSB_BIT 13
`define DUPLEX_BIT 8
`define COLLISION_TEST_ENABLE_BIT 7
`define SPD_MSB_BIT 6
`define ONE_WAY_BIT 5
// status register field positions
`define ST_FOUR_PAIR 15
`define ST_TX100_FULL 14
`define ST_TX100_HALF 13
`define ST_T10_FULL 12
`define ST_T10_HALF 11
`define ST_TWO_PAIR_FULL 10
`define ST_TWO_PAIR_HALF 9
`define ST_EXT_STATUS 8
`define ST_ONE_WAY 7
`define ST_PREAMBLE_SKIP 6
`define ST_NEG_DONE 5
`define ST_FAR_FAULT 4
`define ST_NEG_ABLE 3
`define ST_LINK_UP 2
`define ST_BABBLE 1
`define ST_EXT_REGS 0
// reset values
`define STAT_RESET 16'h7949
`define CTRL_RESET 16'h0000
// sticky latch slots
`define LAT_N 3
`define LAT_FAULT 0
`define LAT_BABBLE 1
`define LAT_LOST 2
// strap capture: synchroniser fill count and saturated value
`define STRAP_SYNC_CNT 2'd2
`define STRAP_DONE 2'd3
`endif

// File: phy_regs_pkg.sv
// types shared by the phy register bank
package phy_regs_pkg;
    typedef enum logic [1:0] {
        SPEED_10 = 2'b00,
        SPEED_100 = 2'b01,
        SPEED_RSV_A = 2'b10,
        SPEED_RSV_B = 2'b11
    } speed_t;
    typedef enum logic [1:0] {
        SEL_CTRL = 2'b00,
        SEL_STAT = 2'b01,
        SEL_EXT = 2'b10,
        SEL_NONE = 2'b11
    } reg_sel_t;
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_ACCESS = 1'b1
    } bus_state_t;
endpackage : phy_regs_pkg

// File: sticky_if.sv
// carrier between the register bank and its sticky status latches
interface sticky_if #(parameter int N = 3);
    logic [N-1:0] event_lvl;
    logic [N-1:0] clear_mask;
    logic [N-1:0] held;
    modport owner(input event_lvl, input clear_mask, output held);
    modport user(output event_lvl, output clear_mask, input held);
endinterface : sticky_if

// File: bit_sync.sv
// two flip-flop synchroniser for pin levels
module bit_sync #(
    parameter int W = 1
) (
    input wire logic i_clock, // system clock
    input wire logic i_sys_rst, // synchronous reset, high
    input wire logic [W-1:0] i_async, // pin levels
    output logic [W-1:0] o_sync // synchronised levels
);
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;

    // first stage is read only by the second
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= i_async;
            stage2_q <= stage1_q;
        end
    end

    assign o_sync = stage2_q;
endmodule : bit_sync

// File: sticky_bank.sv
// set-dominant sticky latches cleared by a masked read
module sticky_bank #(
    parameter int N = 3
) (
    input wire logic i_clock, // system clock
    input wire logic i_sys_rst, // synchronous reset, high
    sticky_if.owner bus // events, clear mask, held bits
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    for (genvar g = 0; g < N; g++) begin : g_lat
        logic bit_q;
        // an event in the clearing cycle wins
        always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
                bit_q <= 1'b0;
            end else if (bus.event_lvl[g]) begin
                bit_q <= 1'b1;
            end else if (bus.clear_mask[g]) begin
                bit_q <= 1'b0;
            end
        end
        assign bus.held[g] = bit_q;

        chk_set_wins: assert property (bus.event_lvl[g] |=> bus.held[g])
            else $error("sticky bit lost its event");
        chk_hold_until_clear: assert property (
            bus.held[g] && !bus.clear_mask[g] |=> bus.held[g])
            else $error("sticky bit dropped without a clear");
    end
endmodule : sticky_bank

// File: phy_basic_control_status_regs.sv
// apb register bank: basic control and basic status of a 10/100 phy
//
// The implementer's own choice: the APB interface to the registers.
`include "phy_regs_consts.svh"
module phy_basic_control_status_regs
    import phy_regs_pkg::*;
#(
    // arbitrary content of the extended status word
    parameter logic [15:0] EXT_STATUS_VALUE = 16'h0000
) (
    input wire logic i_clock, // 50 mhz system clock
    input wire logic i_sys_rst, // synchronous reset, high
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb access phase
    input wire logic i_pwrite, // apb direction, high write
    input wire logic [11:0] i_paddr, // apb byte address
    input wire logic [31:0] i_pwdata, // apb write data
    input wire logic [3:0] i_pstrb, // apb byte strobes
    output logic [31:0] o_prdata, // apb read data
    output logic o_pready, // apb ready
    output logic o_pslverr, // apb error, unmapped address
    input wire logic i_link_up, // link valid level from pma
    input wire logic i_far_fault, // remote fault level
    input wire logic i_babble, // jabber condition level
    input wire logic i_neg_done, // negotiation complete level
    input wire logic i_speed_low_strap, // speed low default pin
    output logic o_duplex_select, // high for full duplex
    output logic o_collision_test_enable, // collision test on
    output logic [1:0] o_speed_code, // {high, low} speed code
    output logic o_speed_100, // code selects 100 mbps
    output logic o_speed_reserved, // code is a reserved value
    output logic o_tx_allowed // transmit path may run
);
    // synchronised pin levels
    logic [4:0] pins_s;
    logic link_now;
    logic fault_now;
    logic babble_now;
    logic neg_now;
    logic strap_now;

    // control fields
    logic duplex_q;
    logic collision_test_enable_q;
    logic spd_msb_q;
    logic spd_lsb_q;
    logic [1:0] strap_cnt_q;
    logic take_strap;

    // bus side state
    bus_state_t st_q;
    reg_sel_t sel_q;
    logic [31:0] prdata_q;
    logic err_q;
    logic [`LAT_N-1:0] snap_q;
    logic done;
    logic wr_ctrl;
    logic rd_stat;
    reg_sel_t sel_now;
    logic [15:0] stat_value;
    logic [15:0] ctrl_value;

    // registered outputs
    logic tx_allowed_q;
    logic speed_100_q;
    logic speed_rsv_q;

    sticky_if #(.N(`LAT_N)) lat_bus();

    // every pin passes two flip-flops before use
    bit_sync #(.W(5)) pin_sync (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_async({i_speed_low_strap, i_neg_done, i_babble, i_far_fault,
                  i_link_up}),
        .o_sync(pins_s)
    );

    assign link_now = pins_s[0];
    assign fault_now = pins_s[1];
    assign babble_now = pins_s[2];
    assign neg_now = pins_s[3];
    assign strap_now = pins_s[4];

    // sticky latches for fault, babble and link loss
    sticky_bank #(.N(`LAT_N)) latches (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .bus(lat_bus.owner)
    );

    // latch events; loss of link latches the low state
    assign lat_bus.event_lvl[`LAT_FAULT] = fault_now;
    assign lat_bus.event_lvl[`LAT_BABBLE] = babble_now;
    assign lat_bus.event_lvl[`LAT_LOST] = ~link_now;
    // a status read clears only what it reported
    assign lat_bus.clear_mask = rd_stat ? snap_q : '0;

    // address decode: aligned word, upper index bits zero
    function automatic reg_sel_t decode_addr(input logic [11:0] a);
        if (a[1:0] != 2'b00) begin
            return SEL_NONE;
        end else if (a[11:2] == `CTRL_IDX) begin
            return SEL_CTRL;
        end else if (a[11:2] == `STAT_IDX) begin
            return SEL_STAT;
        end else if (a[11:2] == `EXT_IDX) begin
            return SEL_EXT;
        end else begin
            return SEL_NONE;
        end
    endfunction : decode_addr

    // status word from fixed abilities and live state
    always_comb begin
        stat_value = '0;
        stat_value[`ST_FOUR_PAIR] = 1'b0;
        stat_value[`ST_TX100_FULL] = 1'b1;
        stat_value[`ST_TX100_HALF] = 1'b1;
        stat_value[`ST_T10_FULL] = 1'b1;
        stat_value[`ST_T10_HALF] = 1'b1;
        stat_value[`ST_TWO_PAIR_FULL] = 1'b0;
        stat_value[`ST_TWO_PAIR_HALF] = 1'b0;
        stat_value[`ST_EXT_STATUS] = 1'b1;
        stat_value[`ST_ONE_WAY] = 1'b0;
        stat_value[`ST_PREAMBLE_SKIP] = 1'b1;
        stat_value[`ST_NEG_DONE] = neg_now;
        stat_value[`ST_FAR_FAULT] = lat_bus.held[`LAT_FAULT];
        stat_value[`ST_NEG_ABLE] = 1'b1;
        stat_value[`ST_LINK_UP] = link_now
            & ~lat_bus.held[`LAT_LOST];
        stat_value[`ST_BABBLE] = lat_bus.held[`LAT_BABBLE];
        stat_value[`ST_EXT_REGS] = 1'b1;
    end

    // control word; unheld bits read zero
    always_comb begin
        ctrl_value = `CTRL_RESET;
        ctrl_value[`SPD_LSB_BIT] = spd_lsb_q;
        ctrl_value[`DUPLEX_BIT] = duplex_q;
        ctrl_value[`COLLISION_TEST_ENABLE_BIT] = collision_test_enable_q;
        ctrl_value[`SPD_MSB_BIT] = spd_msb_q;
        ctrl_value[`ONE_WAY_BIT] = 1'b0;
    end

    assign sel_now = decode_addr(i_paddr);

    // apb phase tracking: setup captures, access completes
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (i_psel) begin
                        st_q <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    if (i_psel && i_penable) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // setup cycle: decode, read value and latch snapshot
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            sel_q <= SEL_NONE;
            err_q <= 1'b0;
            prdata_q <= '0;
            snap_q <= '0;
        end else if (st_q == ST_IDLE && i_psel) begin
            sel_q <= sel_now;
            err_q <= (sel_now == SEL_NONE);
            snap_q <= lat_bus.held;
            if (i_pwrite || sel_now == SEL_NONE) begin
                prdata_q <= '0;
            end else if (sel_now == SEL_CTRL) begin
                prdata_q <= {16'h0000, ctrl_value};
            end else if (sel_now == SEL_STAT) begin
                prdata_q <= {16'h0000, stat_value};
            end else begin
                prdata_q <= {16'h0000, EXT_STATUS_VALUE};
            end
        end
    end

    // access phase ends in its first cycle
    assign done = (st_q == ST_ACCESS) && i_psel && i_penable;
    assign wr_ctrl = done && i_pwrite && !err_q && sel_q == SEL_CTRL;
    assign rd_stat = done && !i_pwrite && !err_q && sel_q == SEL_STAT;
    assign o_pready = done;
    assign o_pslverr = done && err_q;
    assign o_prdata = prdata_q;

    // strap sampled once the synchroniser has filled
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            strap_cnt_q <= 2'd0;
        end else if (strap_cnt_q != `STRAP_DONE) begin
            strap_cnt_q <= strap_cnt_q + 2'd1;
        end
    end
    assign take_strap = (strap_cnt_q == `STRAP_SYNC_CNT);

    // speed low bit: write wins over the strap load
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            spd_lsb_q <= 1'b0;
        end else if (wr_ctrl && i_pstrb[1]) begin
            spd_lsb_q <= i_pwdata[`SPD_LSB_BIT];
        end else if (take_strap) begin
            spd_lsb_q <= strap_now;
        end
    end

    // duplex, collision test, speed high bit
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            duplex_q <= 1'b0;
            collision_test_enable_q <= 1'b0;
            spd_msb_q <= 1'b0;
        end else if (wr_ctrl) begin
            if (i_pstrb[1]) begin
                duplex_q <= i_pwdata[`DUPLEX_BIT];
            end
            if (i_pstrb[0]) begin
                collision_test_enable_q <= i_pwdata[`COLLISION_TEST_ENABLE_BIT];
                spd_msb_q <= i_pwdata[`SPD_MSB_BIT];
            end
        end
    end

    // speed decode and transmit gate
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            speed_100_q <= 1'b0;
            speed_rsv_q <= 1'b0;
            tx_allowed_q <= 1'b0;
        end else begin
            speed_100_q <= ({spd_msb_q, spd_lsb_q}
                == SPEED_100);
            speed_rsv_q <= spd_msb_q;
            tx_allowed_q <= link_now;
        end
    end

    assign o_duplex_select = duplex_q;
    assign o_collision_test_enable = collision_test_enable_q;
    assign o_speed_code = {spd_msb_q, spd_lsb_q};
    assign o_speed_100 = speed_100_q;
    assign o_speed_reserved = speed_rsv_q;
    assign o_tx_allowed = tx_allowed_q;

    // checks on the bank's behaviour
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    sequence stat_read_s;
        done && !i_pwrite && sel_q == SEL_STAT;
    endsequence
    sequence ctrl_read_s;
        done && !i_pwrite && sel_q == SEL_CTRL;
    endsequence
    sequence ctrl_write_lo_s;
        done && i_pwrite && sel_q == SEL_CTRL && i_pstrb[0];
    endsequence
    sequence ctrl_write_hi_s;
        done && i_pwrite && sel_q == SEL_CTRL && i_pstrb[1];
    endsequence

    chk_collision_test_enable_write: assert property (
        ctrl_write_lo_s |=> o_collision_test_enable == $past(i_pwdata[7]))
        else $error("collision test bit not written");
    chk_speed_decode: assert property (
        o_speed_code == 2'b01 |=> o_speed_100 && !o_speed_reserved)
        else $error("speed code 01 not decoded as 100");
    chk_speed_low_write: assert property (
        ctrl_write_hi_s |=> o_speed_code[0] == $past(i_pwdata[13]))
        else $error("speed low bit not written");
    chk_one_way_zero: assert property (
        ctrl_read_s |-> o_prdata[5] == 1'b0)
        else $error("one-way enable read nonzero");
    chk_tx_needs_link: assert property (
        !link_now [*2] |=> !o_tx_allowed)
        else $error("transmit allowed without link");
    chk_status_reset: assert property (
        $past(i_sys_rst) |-> stat_value == `STAT_RESET)
        else $error("status word wrong after reset");
    chk_four_pair_zero: assert property (
        stat_read_s |-> o_prdata[15] == 1'b0)
        else $error("four-pair ability read nonzero");
    chk_tx100_abilities: assert property (
        stat_read_s |-> o_prdata[14:13] == 2'b11)
        else $error("100 tx abilities not one");
    chk_t10_abilities: assert property (
        stat_read_s |-> o_prdata[12:11] == 2'b11)
        else $error("10 abilities not one");
    chk_two_pair_zero: assert property (
        stat_read_s |-> o_prdata[10:9] == 2'b00)
        else $error("two-pair abilities not zero");
    chk_ext_status_bit: assert property (
        stat_read_s |-> o_prdata[8] && o_prdata[31:16] == 16'h0000)
        else $error("extended status bit wrong");
    chk_one_way_ability: assert property (
        stat_read_s |-> !o_prdata[7])
        else $error("one-way ability read nonzero");
    chk_preamble_skip: assert property (
        stat_read_s |-> o_prdata[6])
        else $error("preamble skip ability not one");
    chk_neg_done_bit: assert property (
        stat_read_s |-> o_prdata[5] == $past(neg_now))
        else $error("negotiation bit does not follow state");
    chk_fault_latch: assert property (
        fault_now |=> stat_value[4] [*1] ##0 !rd_stat [*1] |=> stat_value[4])
        else $error("far fault not held");
    chk_neg_ability: assert property (
        stat_read_s |-> o_prdata[3])
        else $error("negotiation ability not one");
    chk_link_low_latch: assert property (
        !link_now ##1 (link_now && !rd_stat) |-> !stat_value[2])
        else $error("link drop not latched low");
    chk_babble_latch: assert property (
        babble_now |=> stat_value[1])
        else $error("babble not latched");
    chk_ext_regs_bit: assert property (
        stat_read_s |-> o_prdata[0])
        else $error("extended register bit not one");
    chk_duplex_write: assert property (
        ctrl_write_hi_s |=> o_duplex_select == $past(i_pwdata[8]))
        else $error("duplex bit not written");
    chk_ctrl_reserved: assert property (
        ctrl_read_s |-> o_prdata[4:0] == 5'h00)
        else $error("reserved control bits nonzero");
endmodule : phy_basic_control_status_regs

// File: mgmt_host.sv
// apb management host model reaching the phy register bank
module mgmt_host (
    input wire logic i_clock, // system clock
    output logic [3:0] o_pstrb, // byte strobes
    input wire logic [31:0] i_prdata, // read data from the bank
    input wire logic i_pready, // ready from the bank
    input wire logic i_pslverr, // error from the bank
    output logic o_psel, // select
    output logic o_penable, // access phase
    output logic o_pwrite, // direction, high write
    output logic [11:0] o_paddr, // byte address
    output logic [31:0] o_pwdata // write data
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus from time zero
    initial begin
        o_pstrb = 4'h0;
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 12'h000;
        o_pwdata = 32'h0000_0000;
    end

    // one transfer; the request stands until ready is seen at an edge, for at most 20 edges
    task automatic xfer(input logic wr, input logic [11:0] addr,
            input logic [31:0] wd, input logic [3:0] strb,
            output logic [31:0] rd, output logic err, output logic ok);
        int n;
        logic rdy;
        n = 0;
        rdy = 1'b0;
        rd = 32'h0000_0000;
        err = 1'b0;
        @(posedge i_clock);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= wr;
        o_paddr <= addr;
        o_pwdata <= wd;
        o_pstrb <= strb;
        @(posedge i_clock);
        o_penable <= 1'b1;
        // ready and answer are taken at the rising edge that samples them
        while (!rdy && n < 20) begin
            @(posedge i_clock);
            rdy = (i_pready === 1'b1);
            rd = i_prdata;
            err = i_pslverr;
            n++;
        end
        // released data no longer shows the last value
        o_pstrb <= 4'h0;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_pwdata <= ~wd;
        ok = rdy;
    endtask : xfer
endmodule : mgmt_host

// File: phy_basic_control_status_regs_bench.sv
// self-checking bench for the phy control and status register bank
module phy_basic_control_status_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_link_up = 1'b0;
    logic i_far_fault = 1'b0;
    logic i_babble = 1'b0;
    logic i_neg_done = 1'b0;
    logic i_speed_low_strap = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata;
    logic dup, col, s100, srsv, txok;
    logic [1:0] code;
    int bad_count = 0;
    int total_checks = 0;

    // 50 mhz clock
    always #10 i_clock = ~i_clock;

    phy_basic_control_status_regs phy_basic_control_status_regs_inst (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_link_up(i_link_up),
        .i_far_fault(i_far_fault), .i_babble(i_babble),
        .i_neg_done(i_neg_done), .i_speed_low_strap(i_speed_low_strap),
        .o_duplex_select(dup), .o_collision_test_enable(col),
        .o_speed_code(code), .o_speed_100(s100),
        .o_speed_reserved(srsv), .o_tx_allowed(txok));

    mgmt_host mgmt_host_inst (
        .i_clock(i_clock), .o_pstrb(pstrb), .i_prdata(prdata),
        .i_pready(pready),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one bus access with byte strobes, a hang ends the run
    task automatic acc_s(input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic [31:0] exp, input logic eexp,
            input logic [3:0] s);
        logic [31:0] r;
        logic e, ok;
        mgmt_host_inst.xfer(wr, a, d, s, r, e, ok);
        if (!ok) begin
            bad_count++;
            $display("mismatch at %0t: ready %h expected %h", $time, 0, 1);
            stop_test();
        end
        if (!wr) begin
            check(r, exp);
        end
        check({31'h0, e}, {31'h0, eexp});
    endtask : acc_s

    // full-word access
    task automatic acc(input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic [31:0] exp, input logic eexp);
        acc_s(wr, a, d, exp, eexp, 4'hf);
    endtask : acc

    // control side outputs: duplex, collision_test_enable, code, 100, reserved
    task automatic outs(input logic [31:0] exp);
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        check({26'h0, dup, col, code, s100, srsv}, exp);
    endtask : outs

    task automatic pins(input logic l, f, b, n);
        i_link_up <= l;
        i_far_fault <= f;
        i_babble <= b;
        i_neg_done <= n;
        repeat (6) @(posedge i_clock);
    endtask : pins

    task automatic do_reset(input logic strap);
        i_sys_rst <= 1'b1;
        i_speed_low_strap <= strap;
        repeat (12) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_clock);
    endtask : do_reset

    task automatic t_reset_values();
        acc(0, 12'h004, 0, 32'h7949, 0);
        acc(0, 12'h000, 0, 32'h0, 0);
        outs(32'h00);
        $display("test reset_values done");
    endtask : t_reset_values

    task automatic t_control();
        acc(1, 12'h000, 32'hffff_ffff, 0, 0);
        acc(0, 12'h000, 0, 32'h21c0, 0);
        outs(32'h3d);
        acc(1, 12'h000, 32'h0000_2000, 0, 0);
        acc(0, 12'h000, 0, 32'h2000, 0);
        outs(32'h06);
        acc(1, 12'h000, 32'h0000_0040, 0, 0);
        outs(32'h09);
        // lane one only: duplex and speed low change, lane zero kept
        acc_s(1, 12'h000, 32'hffff_ffff, 0, 0, 4'h2);
        acc(0, 12'h000, 0, 32'h2140, 0);
        acc(1, 12'h000, 32'h0000_0000, 0, 0);
        outs(32'h00);
        acc(1, 12'h004, 32'h0000_0000, 0, 0);
        acc(0, 12'h004, 0, 32'h7949, 0);
        acc(0, 12'h03c, 0, 32'h0, 0);
        acc(0, 12'h008, 0, 32'h0, 1);
        acc(0, 12'h006, 0, 32'h0, 1);
        $display("test control done");
    endtask : t_control

    task automatic t_latches();
        pins(0, 1, 1, 1);
        pins(0, 0, 0, 1);
        acc(0, 12'h004, 0, 32'h797b, 0);
        acc(0, 12'h004, 0, 32'h7969, 0);
        pins(0, 0, 0, 0);
        acc(0, 12'h004, 0, 32'h7949, 0);
        $display("test latches done");
    endtask : t_latches

    task automatic t_link();
        pins(1, 0, 0, 0);
        check({31'h0, txok}, 32'h1);
        acc(0, 12'h004, 0, 32'h7949, 0);
        acc(0, 12'h004, 0, 32'h794d, 0);
        pins(0, 0, 0, 0);
        check({31'h0, txok}, 32'h0);
        pins(1, 0, 0, 0);
        acc(0, 12'h004, 0, 32'h7949, 0);
        acc(0, 12'h004, 0, 32'h794d, 0);
        $display("test link done");
    endtask : t_link

    task automatic t_strap();
        do_reset(1'b1);
        acc(0, 12'h000, 0, 32'h2000, 0);
        outs(32'h06);
        $display("test strap done");
    endtask : t_strap

    // main sequence
    initial begin
        do_reset(1'b0);
        t_reset_values();
        t_control();
        t_latches();
        t_link();
        t_strap();
        stop_test();
    end
endmodule : phy_basic_control_status_regs_bench
